// [logic/sdram_cmd_bank.sv]
// Write beat FIFO and the SDRAM command decoder with per-bank state tracking.
`timescale 1ns/1ps

module beat_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_t;
	fifo_st_t q;
	fifo_st_t d;
	logic do_push;
	logic do_pop;

	assign in_ready = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];

	always_comb begin
		d = q;
		do_push = in_valid && in_ready;
		do_pop = out_valid && out_ready;
		if (do_push) begin
			d.mem[q.wp] = in_data;
			d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
		end
		if (do_pop) begin
			d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
		end
		if (do_push && !do_pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // beat_fifo

module sdram_cmd_bank (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Command pins, sampled on the rising edge.
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [11:0] addr,
	input wire logic bank_select_bit0,
	input wire logic bank_select_bit1,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [15:0] dq_in,
	// Read output enables per byte.
	output logic rd_low_oe,
	output logic rd_high_oe,
	// Status.
	output sdram_cmd_pkg::dev_mode_t dev_mode,
	output sdram_cmd_pkg::bank_st_t [3:0] bank_state,
	output logic [11:0] mode_reg,
	output logic [11:0] active_row,
	output logic [11:0] refresh_row,
	output logic illegal_cmd,
	// Write beats towards the array.
	output logic write_buf_ready,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [1:0] wr_bank,
	output logic [7:0] wr_col,
	output logic [1:0] wr_byte_en,
	output logic [15:0] wr_data
);
	typedef struct packed {
		sdram_cmd_pkg::dev_mode_t mode;
		logic cke_prev;
		logic [7:0] gcnt;
		sdram_cmd_pkg::bank_st_t [3:0] bst;
		logic [3:0][7:0] bcnt;
		logic [1:0] last_bank;
		logic [7:0] wcol;
		logic [11:0] mode_reg;
		logic [11:0] act_row;
		logic [11:0] ref_row;
		logic [1:0] rd_en1;
		logic [1:0] rd_oe;
		logic illegal;
	} state_t;
	state_t q;
	state_t d;
	logic [2:0] cmd;
	logic [1:0] tb;
	logic idle_cmd;
	logic all_idle;
	logic any_burst;
	logic w_beat;
	logic r_beat;
	logic push;
	logic [7:0] push_col;
	logic [1:0] push_bank;
	logic [1:0] byte_en;
	logic fifo_in_ready;
	logic [sdram_cmd_pkg::WBEAT_W-1:0] fifo_out;

	always_comb begin
		d = q;
		d.illegal = 1'b0;
		d.cke_prev = cke;
		cmd = cs_n ? sdram_cmd_pkg::CMD_NO_OP : {ras_n, cas_n, we_n};
		tb = {bank_select_bit1, bank_select_bit0};
		idle_cmd = (cmd == sdram_cmd_pkg::CMD_NO_OP);
		byte_en = ~{high_byte_mask, low_byte_mask};
		all_idle = 1'b1;
		any_burst = 1'b0;
		for (int i = 0; i < sdram_cmd_pkg::BANKS; i++) begin
			all_idle = all_idle && (q.bst[i] == sdram_cmd_pkg::BANK_IDLE);
			any_burst = any_burst || (q.bst[i] inside {sdram_cmd_pkg::BANK_READ,
				sdram_cmd_pkg::BANK_WRITE, sdram_cmd_pkg::BANK_READ_AP,
				sdram_cmd_pkg::BANK_WRITE_AP});
		end
		w_beat = (q.bst[q.last_bank] inside {sdram_cmd_pkg::BANK_WRITE,
			sdram_cmd_pkg::BANK_WRITE_AP}) && (q.bcnt[q.last_bank] > 8'h01);
		r_beat = (q.bst[q.last_bank] inside {sdram_cmd_pkg::BANK_READ,
			sdram_cmd_pkg::BANK_READ_AP}) && (q.bcnt[q.last_bank] > 8'h01);
		push = 1'b0;
		push_col = q.wcol;
		push_bank = q.last_bank;
		if (!q.cke_prev) begin
			// The edge is gated off; only the clock-gate exit paths act here.
			if (cke) begin
				case (q.mode)
					sdram_cmd_pkg::DEV_POWER_DOWN: begin
						d.mode = sdram_cmd_pkg::DEV_NORMAL;
						d.illegal = !idle_cmd;
					end
					sdram_cmd_pkg::DEV_SELF_REFRESH: begin
						d.mode = sdram_cmd_pkg::DEV_SR_EXIT;
						d.gcnt = sdram_cmd_pkg::SR_EXIT_CYC;
						d.illegal = !idle_cmd;
					end
					sdram_cmd_pkg::DEV_SUSPEND: begin
						d.mode = sdram_cmd_pkg::DEV_NORMAL;
					end
					default: begin
					end
				endcase
			end
			// Gate low at both edges: the current low-power mode is held.
		end else if (!cke && q.mode == sdram_cmd_pkg::DEV_NORMAL) begin
			if (all_idle && idle_cmd) begin
				d.mode = sdram_cmd_pkg::DEV_POWER_DOWN;
			end else if (all_idle && cmd == sdram_cmd_pkg::CMD_REFRESH) begin
				d.mode = sdram_cmd_pkg::DEV_SELF_REFRESH;
				d.ref_row = q.ref_row + 1'b1;
			end else begin
				d.mode = sdram_cmd_pkg::DEV_SUSPEND;
				d.illegal = !any_burst;
			end
		end else if (cke || q.mode != sdram_cmd_pkg::DEV_NORMAL) begin
			// Timers run first so that a command in the same edge overrides them.
			for (int i = 0; i < sdram_cmd_pkg::BANKS; i++) begin
				if (q.bcnt[i] > 8'h01) begin
					d.bcnt[i] = q.bcnt[i] - 8'h01;
				end else begin
					case (q.bst[i])
						sdram_cmd_pkg::BANK_ACTIVATING, sdram_cmd_pkg::BANK_READ,
						sdram_cmd_pkg::BANK_WRITE: begin
							d.bst[i] = sdram_cmd_pkg::BANK_ACTIVE;
						end
						sdram_cmd_pkg::BANK_READ_AP, sdram_cmd_pkg::BANK_WRITE_AP: begin
							d.bst[i] = sdram_cmd_pkg::BANK_PRECHARGING;
							d.bcnt[i] = sdram_cmd_pkg::PRECHARGE_CYC;
						end
						sdram_cmd_pkg::BANK_PRECHARGING: begin
							d.bst[i] = sdram_cmd_pkg::BANK_IDLE;
						end
						default: begin
						end
					endcase
				end
			end
			if (q.mode != sdram_cmd_pkg::DEV_NORMAL) begin
				if (q.gcnt > 8'h01) begin
					d.gcnt = q.gcnt - 8'h01;
				end else begin
					d.mode = sdram_cmd_pkg::DEV_NORMAL;
				end
			end
			if (w_beat) begin
				push = 1'b1;
				d.wcol = q.wcol + 8'h01;
			end
			d.rd_en1 = {2{r_beat}} & byte_en;
			if (q.mode != sdram_cmd_pkg::DEV_NORMAL) begin
				d.illegal = !idle_cmd;
			end else begin
				case (cmd)
					sdram_cmd_pkg::CMD_ACTIVATE: begin
						if (q.bst[tb] == sdram_cmd_pkg::BANK_IDLE) begin
							d.bst[tb] = sdram_cmd_pkg::BANK_ACTIVATING;
							d.bcnt[tb] = sdram_cmd_pkg::ACT_TO_COL_CYC;
							d.act_row = addr;
						end else begin
							d.illegal = 1'b1;
						end
					end
					sdram_cmd_pkg::CMD_READ, sdram_cmd_pkg::CMD_WRITE: begin
						if (q.bst[tb] inside {sdram_cmd_pkg::BANK_ACTIVE, sdram_cmd_pkg::BANK_READ,
							sdram_cmd_pkg::BANK_WRITE}) begin
							// An older burst in another bank is cut; with auto precharge it closes.
							if (q.last_bank != tb && q.bst[q.last_bank] inside
								{sdram_cmd_pkg::BANK_READ, sdram_cmd_pkg::BANK_WRITE}) begin
								d.bst[q.last_bank] = sdram_cmd_pkg::BANK_ACTIVE;
								d.bcnt[q.last_bank] = 8'h00;
							end else if (q.last_bank != tb && q.bst[q.last_bank] inside
								{sdram_cmd_pkg::BANK_READ_AP, sdram_cmd_pkg::BANK_WRITE_AP}) begin
								d.bst[q.last_bank] = sdram_cmd_pkg::BANK_PRECHARGING;
								d.bcnt[q.last_bank] = sdram_cmd_pkg::PRECHARGE_CYC;
							end
							if (cmd == sdram_cmd_pkg::CMD_READ) begin
								d.bst[tb] = addr[sdram_cmd_pkg::AUTO_PRE_BIT] ?
									sdram_cmd_pkg::BANK_READ_AP : sdram_cmd_pkg::BANK_READ;
								push = 1'b0;
								d.rd_en1 = byte_en;
							end else begin
								d.bst[tb] = addr[sdram_cmd_pkg::AUTO_PRE_BIT] ?
									sdram_cmd_pkg::BANK_WRITE_AP : sdram_cmd_pkg::BANK_WRITE;
								push = 1'b1;
								push_bank = tb;
								push_col = addr[sdram_cmd_pkg::COL_W-1:0];
								d.rd_en1 = 2'h0;
							end
							d.bcnt[tb] = sdram_cmd_pkg::BURST_BEATS;
							d.last_bank = tb;
							d.wcol = addr[sdram_cmd_pkg::COL_W-1:0] + 8'h01;
						end else begin
							d.illegal = 1'b1;
						end
					end
					sdram_cmd_pkg::CMD_BURST_STOP: begin
						if (q.bst[q.last_bank] inside {sdram_cmd_pkg::BANK_READ,
							sdram_cmd_pkg::BANK_WRITE}) begin
							d.bst[q.last_bank] = sdram_cmd_pkg::BANK_ACTIVE;
							d.bcnt[q.last_bank] = 8'h00;
							push = 1'b0;
							d.rd_en1 = 2'h0;
						end else begin
							d.illegal = 1'b1;
						end
					end
					sdram_cmd_pkg::CMD_PRECHARGE: begin
						for (int i = 0; i < sdram_cmd_pkg::BANKS; i++) begin
							if (addr[sdram_cmd_pkg::AUTO_PRE_BIT] || tb == 2'(i)) begin
								if (q.bst[i] inside {sdram_cmd_pkg::BANK_ACTIVE,
									sdram_cmd_pkg::BANK_READ, sdram_cmd_pkg::BANK_WRITE}) begin
									d.bst[i] = sdram_cmd_pkg::BANK_PRECHARGING;
									d.bcnt[i] = sdram_cmd_pkg::PRECHARGE_CYC;
									if (2'(i) == q.last_bank) begin
										push = 1'b0;
										d.rd_en1 = 2'h0;
									end
								end else if (q.bst[i] != sdram_cmd_pkg::BANK_IDLE) begin
									d.illegal = 1'b1;
								end
								// An idle bank is left as it is.
							end
						end
					end
					sdram_cmd_pkg::CMD_REFRESH: begin
						if (all_idle) begin
							d.mode = sdram_cmd_pkg::DEV_REFRESHING;
							d.gcnt = sdram_cmd_pkg::REFRESH_CYC;
							d.ref_row = q.ref_row + 1'b1;
						end else begin
							d.illegal = 1'b1;
						end
					end
					sdram_cmd_pkg::CMD_LOAD_MODE: begin
						if (all_idle) begin
							d.mode_reg = addr;
							d.mode = sdram_cmd_pkg::DEV_MODE_LOAD;
							d.gcnt = sdram_cmd_pkg::MODE_LOAD_CYC;
						end else begin
							d.illegal = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			d.rd_oe = q.rd_en1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.mode <= sdram_cmd_pkg::DEV_NORMAL;
			q.cke_prev <= 1'b0;
			q.gcnt <= 8'h00;
			q.bst <= '{default: sdram_cmd_pkg::BANK_IDLE};
			q.bcnt <= '0;
			q.last_bank <= 2'h0;
			q.wcol <= 8'h00;
			q.mode_reg <= sdram_cmd_pkg::MODE_REG_RESET;
			q.act_row <= sdram_cmd_pkg::ROW_RESET;
			q.ref_row <= sdram_cmd_pkg::ROW_RESET;
			q.rd_en1 <= 2'h0;
			q.rd_oe <= 2'h0;
			q.illegal <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// A full buffer drops the beat, because the bus cannot be stalled; write_buf_ready shows it.
	beat_fifo #(.WIDTH(sdram_cmd_pkg::WBEAT_W), .DEPTH(sdram_cmd_pkg::FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({push_bank, push_col, byte_en, dq_in}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fifo_out)
	);

	assign write_buf_ready = fifo_in_ready;
	assign {wr_bank, wr_col, wr_byte_en, wr_data} = fifo_out;
	assign rd_low_oe = q.rd_oe[0];
	assign rd_high_oe = q.rd_oe[1];
	assign dev_mode = q.mode;
	assign bank_state = q.bst;
	assign mode_reg = q.mode_reg;
	assign active_row = q.act_row;
	assign refresh_row = q.ref_row;
	assign illegal_cmd = q.illegal;
endmodule // sdram_cmd_bank

// [logic/sdram_cmd_pkg.sv]
// Shared encodings, layouts and timing counts for the SDRAM command and bank state block.
package sdram_cmd_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int ACT_TO_COL_NS = 20;
	localparam int PRECHARGE_NS = 20;
	localparam int MODE_LOAD_NS = 40;
	localparam int SR_EXIT_NS = 80;
	localparam int REFRESH_NS = 80;
	localparam logic [7:0] ACT_TO_COL_CYC = 8'((ACT_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PRECHARGE_CYC = 8'((PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MODE_LOAD_CYC = 8'((MODE_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SR_EXIT_CYC = 8'((SR_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] REFRESH_CYC = 8'((REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BURST_BEATS = 8'h04;
	localparam int BANKS = 4;
	localparam int ADDR_W = 12;
	localparam int COL_W = 8;
	localparam int DATA_W = 16;
	localparam int AUTO_PRE_BIT = 10;
	localparam int WBEAT_W = 2 + COL_W + 2 + DATA_W;
	localparam int FIFO_DEPTH = 8;
	localparam logic [ADDR_W-1:0] MODE_REG_RESET = 12'h000;
	localparam logic [ADDR_W-1:0] ROW_RESET = 12'h000;
	// Command codes are the row, column and write strobes in that order.
	localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_BURST_STOP = 3'h6;
	localparam logic [2:0] CMD_NO_OP = 3'h7;
	typedef enum logic [7:0] {
		BANK_IDLE = 8'h01, BANK_ACTIVATING = 8'h02, BANK_ACTIVE = 8'h04, BANK_READ = 8'h08,
		BANK_WRITE = 8'h10, BANK_READ_AP = 8'h20, BANK_WRITE_AP = 8'h40, BANK_PRECHARGING = 8'h80
	} bank_st_t;
	typedef enum logic [6:0] {
		DEV_NORMAL = 7'h01, DEV_POWER_DOWN = 7'h02, DEV_SELF_REFRESH = 7'h04,
		DEV_SUSPEND = 7'h08, DEV_REFRESHING = 7'h10, DEV_MODE_LOAD = 7'h20, DEV_SR_EXIT = 7'h40
	} dev_mode_t;
endpackage

// [verif/sdram_cmd_bank_assertions.sv]
// Concurrent checks on the ports of the SDRAM command and bank state block.
`timescale 1ns/1ps
module sdram_cmd_bank_assertions (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Command pins.
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [11:0] addr,
	input wire logic bank_select_bit0,
	input wire logic bank_select_bit1,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [15:0] dq_in,
	// Observed outputs.
	input wire logic rd_low_oe,
	input wire logic rd_high_oe,
	input wire sdram_cmd_pkg::dev_mode_t dev_mode,
	input wire sdram_cmd_pkg::bank_st_t [3:0] bank_state,
	input wire logic [11:0] mode_reg,
	input wire logic [11:0] active_row,
	input wire logic [11:0] refresh_row,
	input wire logic illegal_cmd,
	input wire logic wr_valid,
	input wire logic [7:0] wr_col,
	input wire logic [1:0] wr_byte_en,
	input wire logic [15:0] wr_data
);
	// Gate level of the previous edge; it starts low so the first edge is never taken.
	logic ck_q;
	logic [2:0] cmd;
	logic [1:0] bk;
	logic tk;
	logic idle;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ck_q <= 1'b0;
		end else begin
			ck_q <= cke;
		end
	end
	assign cmd = {ras_n, cas_n, we_n};
	assign bk = {bank_select_bit1, bank_select_bit0};
	assign tk = !cs_n && cke && ck_q && dev_mode == sdram_cmd_pkg::DEV_NORMAL;
	assign idle = bank_state == {4{sdram_cmd_pkg::BANK_IDLE}};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_mode_capture: assert property (
		tk && idle && cmd == sdram_cmd_pkg::CMD_LOAD_MODE |=> mode_reg == $past(addr))
		else $error("mode word not captured");
	a_row_open: assert property (
		tk && cmd == sdram_cmd_pkg::CMD_ACTIVATE && bank_state[bk] == sdram_cmd_pkg::BANK_IDLE
		|=> active_row == $past(addr)
		&& bank_state[$past(bk)] == sdram_cmd_pkg::BANK_ACTIVATING)
		else $error("row open not taken");
	a_col_delay: assert property (
		tk && cmd == sdram_cmd_pkg::CMD_ACTIVATE && bank_state[bk] == sdram_cmd_pkg::BANK_IDLE
		##1 cke |=> bank_state[$past(bk, 2)] == sdram_cmd_pkg::BANK_ACTIVE)
		else $error("bank not active after delay");
	a_idle_pre: assert property (
		tk && cmd == sdram_cmd_pkg::CMD_PRECHARGE && !addr[10]
		&& bank_state[bk] == sdram_cmd_pkg::BANK_IDLE
		|=> bank_state[$past(bk)] == sdram_cmd_pkg::BANK_IDLE && !illegal_cmd)
		else $error("precharge of idle bank changed it");
	a_auto_ref: assert property (
		tk && idle && cmd == sdram_cmd_pkg::CMD_REFRESH
		|=> dev_mode == sdram_cmd_pkg::DEV_REFRESHING
		&& refresh_row == $past(refresh_row) + 12'h001)
		else $error("auto refresh not started");
	a_pd_entry: assert property (
		!cke && ck_q && dev_mode == sdram_cmd_pkg::DEV_NORMAL && idle
		&& (cs_n || cmd == sdram_cmd_pkg::CMD_NO_OP)
		|=> dev_mode == sdram_cmd_pkg::DEV_POWER_DOWN)
		else $error("power-down not entered");
	a_gate_hold: assert property (
		!cke && !ck_q && dev_mode inside {sdram_cmd_pkg::DEV_POWER_DOWN,
		sdram_cmd_pkg::DEV_SELF_REFRESH, sdram_cmd_pkg::DEV_SUSPEND} |=> $stable(dev_mode))
		else $error("low-power mode left with gate low");
	a_pd_exit: assert property (
		dev_mode == sdram_cmd_pkg::DEV_POWER_DOWN && cke
		|=> dev_mode == sdram_cmd_pkg::DEV_NORMAL)
		else $error("power-down exit late");
	a_wr_mask: assert property (
		tk && cmd == sdram_cmd_pkg::CMD_WRITE && bank_state[bk] == sdram_cmd_pkg::BANK_ACTIVE
		&& !wr_valid |=> wr_valid && wr_byte_en == ~$past({high_byte_mask, low_byte_mask})
		&& wr_col == $past(addr[7:0]) && wr_data == $past(dq_in))
		else $error("write beat wrong");
	a_rd_mask: assert property (
		tk && cmd == sdram_cmd_pkg::CMD_READ && bank_state[bk] == sdram_cmd_pkg::BANK_ACTIVE
		##1 cke |=> rd_low_oe == !$past(low_byte_mask, 2)
		&& rd_high_oe == !$past(high_byte_mask, 2))
		else $error("read mask delay wrong");
	a_bad_read: assert property (
		tk && cmd == sdram_cmd_pkg::CMD_READ && bank_state[bk] == sdram_cmd_pkg::BANK_IDLE
		|=> illegal_cmd)
		else $error("read of idle bank not flagged");
endmodule // sdram_cmd_bank_assertions

bind sdram_cmd_bank sdram_cmd_bank_assertions sdram_cmd_bank_assertions_inst (.*);

// [verif/sdram_ctrl_model.sv]
// Memory controller model that drives the SDRAM command pins and drains write beats.
`timescale 1ns/1ps
module sdram_ctrl_model (
	// Clock.
	input wire logic clk,
	// Command pins.
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic cke,
	output logic [11:0] addr,
	output logic [1:0] bank,
	output logic [1:0] mask,
	output logic [15:0] dq,
	// Write beat drain.
	output logic wr_ready
);
	initial begin
		{cs_n, ras_n, cas_n, we_n, cke} = 5'h1f;
		addr = 12'h000;
		bank = 2'h0;
		mask = 2'h0;
		dq = 16'h0000;
		wr_ready = 1'b0;
	end
	// One command per falling edge, so the pins are steady around each rising edge.
	task automatic send(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m, input logic [15:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = c;
		bank = b;
		addr = a;
		mask = m;
		dq = d;
	endtask
	// Inhibit cycles; the command, address and data lines toggle so a stale value can never look valid.
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			cs_n = 1'b1;
			{ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
			addr = ~addr;
			dq = ~dq;
		end
	endtask
endmodule // sdram_ctrl_model

// [verif/test_sdram_cmd_bank.sv]
// Self-checking testbench for the SDRAM command and bank state block.
`timescale 1ns/1ps
module test_sdram_cmd_bank;
	logic clk;
	logic rst_n;
	logic cs_n, ras_n, cas_n, we_n, cke, wr_ready;
	logic rd_low_oe, rd_high_oe, illegal_cmd, write_buf_ready, wr_valid;
	logic [11:0] addr, mode_reg, active_row, refresh_row;
	logic [1:0] bank, mask, wr_bank, wr_byte_en;
	logic [15:0] dq, wr_data;
	logic [7:0] wr_col;
	sdram_cmd_pkg::dev_mode_t dev_mode;
	sdram_cmd_pkg::bank_st_t [3:0] bank_state;
	int mismatches = 0;
	int check_count = 0;
	sdram_ctrl_model sdram_ctrl_model_inst (.*);
	sdram_cmd_bank sdram_cmd_bank_inst (.*, .bank_select_bit0(bank[0]),
		.bank_select_bit1(bank[1]), .low_byte_mask(mask[0]), .high_byte_mask(mask[1]),
		.dq_in(dq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m = 2'h0);
		sdram_ctrl_model_inst.send(c, b, a, m, 16'hbe5a);
	endtask
	task automatic gap(input int n);
		sdram_ctrl_model_inst.idle(n);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic t_mode();
		cmd(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'ha5c);
		gap(1);
		chk({dev_mode, mode_reg}, {sdram_cmd_pkg::DEV_MODE_LOAD, 12'ha5c});
		gap(int'(sdram_cmd_pkg::MODE_LOAD_CYC));
		chk(dev_mode, sdram_cmd_pkg::DEV_NORMAL);
	endtask
	// Two bursts fill the write buffer while the drain stalls; a third is dropped.
	task automatic t_write();
		int i;
		cmd(sdram_cmd_pkg::CMD_ACTIVATE, 2'h1, 12'h3c1);
		gap(1);
		chk({bank_state[1], active_row}, {sdram_cmd_pkg::BANK_ACTIVATING, 12'h3c1});
		gap(1);
		chk(bank_state[1], sdram_cmd_pkg::BANK_ACTIVE);
		for (i = 0; i < 3; i++) begin
			cmd(sdram_cmd_pkg::CMD_WRITE, 2'h1, 12'(16 * i), 2'h1);
			gap(3);
		end
		// The last burst's timer ends one edge after its fourth beat, hence two idle cycles.
		gap(2);
		chk({write_buf_ready, bank_state[1]}, {1'b0, sdram_cmd_pkg::BANK_ACTIVE});
		sdram_ctrl_model_inst.wr_ready = 1'b1;
		for (i = 0; i < 8; i++) begin
			chk({wr_valid, wr_bank, wr_byte_en, wr_col}, {5'h16, 8'(16 * (i / 4) + i % 4)});
			chk(wr_data, (i % 2) ? 16'h41a5 : 16'hbe5a);
			@(negedge clk);
		end
		sdram_ctrl_model_inst.wr_ready = 1'b0;
		chk({wr_valid, write_buf_ready}, 2'h1);
	endtask
	task automatic t_read();
		cmd(sdram_cmd_pkg::CMD_READ, 2'h1, 12'h000, 2'h2);
		gap(1);
		chk(bank_state[1], sdram_cmd_pkg::BANK_READ);
		gap(1);
		chk({rd_high_oe, rd_low_oe}, 2'h1);
		cmd(sdram_cmd_pkg::CMD_PRECHARGE, 2'h1, 12'h000);
		gap(1);
		chk(bank_state[1], sdram_cmd_pkg::BANK_PRECHARGING);
		cmd(sdram_cmd_pkg::CMD_ACTIVATE, 2'h2, 12'h0f0);
		gap(1);
		chk(bank_state[1], sdram_cmd_pkg::BANK_IDLE);
		cmd(sdram_cmd_pkg::CMD_READ, 2'h2, 12'h400);
		gap(1);
		chk(bank_state[2], sdram_cmd_pkg::BANK_READ_AP);
		gap(8);
		chk(bank_state[2], sdram_cmd_pkg::BANK_IDLE);
	endtask
	task automatic t_stop();
		cmd(sdram_cmd_pkg::CMD_ACTIVATE, 2'h0, 12'h011);
		cmd(sdram_cmd_pkg::CMD_ACTIVATE, 2'h3, 12'h022);
		gap(1);
		// The write closes itself, so the read to another bank starts its precharge.
		cmd(sdram_cmd_pkg::CMD_WRITE, 2'h0, 12'h404);
		cmd(sdram_cmd_pkg::CMD_READ, 2'h3, 12'h008);
		cmd(sdram_cmd_pkg::CMD_BURST_STOP, 2'h1, 12'h000);
		gap(1);
		chk({bank_state[3], bank_state[0]},
			{sdram_cmd_pkg::BANK_ACTIVE, sdram_cmd_pkg::BANK_IDLE});
		cmd(sdram_cmd_pkg::CMD_PRECHARGE, 2'h1, 12'h400);
		gap(1);
		chk({bank_state[3], bank_state[1], bank_state[0]}, {sdram_cmd_pkg::BANK_PRECHARGING,
			sdram_cmd_pkg::BANK_IDLE, sdram_cmd_pkg::BANK_IDLE});
		gap(1);
		chk(bank_state, {4{sdram_cmd_pkg::BANK_IDLE}});
		cmd(sdram_cmd_pkg::CMD_READ, 2'h2, 12'h000);
		gap(1);
		chk({illegal_cmd, bank_state[2]}, {1'b1, sdram_cmd_pkg::BANK_IDLE});
		cmd(sdram_cmd_pkg::CMD_PRECHARGE, 2'h2, 12'h000);
		gap(1);
		chk({illegal_cmd, bank_state[2]}, {1'b0, sdram_cmd_pkg::BANK_IDLE});
	endtask
	task automatic t_refresh();
		cmd(sdram_cmd_pkg::CMD_REFRESH, 2'h0, 12'hfff);
		gap(1);
		chk({dev_mode, refresh_row}, {sdram_cmd_pkg::DEV_REFRESHING, 12'h001});
		gap(int'(sdram_cmd_pkg::REFRESH_CYC));
		cmd(sdram_cmd_pkg::CMD_REFRESH, 2'h0, 12'h000);
		sdram_ctrl_model_inst.cke = 1'b0;
		gap(3);
		chk({dev_mode, refresh_row}, {sdram_cmd_pkg::DEV_SELF_REFRESH, 12'h002});
		sdram_ctrl_model_inst.cke = 1'b1;
		gap(1);
		chk(dev_mode, sdram_cmd_pkg::DEV_SR_EXIT);
		repeat (6) cmd(sdram_cmd_pkg::CMD_NO_OP, 2'h0, 12'h000);
		gap(1);
		chk(dev_mode, sdram_cmd_pkg::DEV_NORMAL);
	endtask
	task automatic t_power();
		sdram_ctrl_model_inst.cke = 1'b0;
		gap(1);
		chk(dev_mode, sdram_cmd_pkg::DEV_POWER_DOWN);
		gap(2);
		chk(dev_mode, sdram_cmd_pkg::DEV_POWER_DOWN);
		sdram_ctrl_model_inst.cke = 1'b1;
		gap(1);
		chk(dev_mode, sdram_cmd_pkg::DEV_NORMAL);
		cmd(sdram_cmd_pkg::CMD_ACTIVATE, 2'h0, 12'h055);
		gap(2);
		chk(bank_state[0], sdram_cmd_pkg::BANK_ACTIVE);
		cmd(sdram_cmd_pkg::CMD_READ, 2'h0, 12'h000);
		gap(1);
		sdram_ctrl_model_inst.cke = 1'b0;
		gap(1);
		chk(dev_mode, sdram_cmd_pkg::DEV_SUSPEND);
		sdram_ctrl_model_inst.cke = 1'b1;
		gap(1);
		chk(dev_mode, sdram_cmd_pkg::DEV_NORMAL);
		cmd(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0, 12'h000);
		gap(1);
		chk(bank_state[0], sdram_cmd_pkg::BANK_PRECHARGING);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// The scenarios need about 100 cycles; twenty times that means a hang.
	initial begin
		#40000;
		mismatches++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		gap(2);
		t_mode();
		t_write();
		t_read();
		t_stop();
		t_refresh();
		t_power();
		complete_run();
	end
endmodule // test_sdram_cmd_bank
